// ===== core/csp_top.sv
// Purpose: clocked 8-bit serial shift port with APB registers
// Assumes: pin inputs synchronous to pclk; one clock domain
// Notes:   instructions of the core appear as APB writes and reads
//
// Operation
// - done flag goes to 1 when eight bits have been shifted.
// - done flag clears when interrupt taken or skip instruction skips.
// - interrupt-mode bit picks interrupt request or skip testing.
// - start instruction clears done flag, then shifting begins.
// - serial control register written from and read back to accumulator.
// - external clock keeps shifting; internal clock stops at completion.
// - external clock: flag set after eight pulses following start.
// - slave drives ready line high as output at setup.
// - slave issues start first, then drives ready line low.
// - slave raises ready line after reception, before processing.
// - shift register loaded from accumulator pair before transmission.
// - clock select 00 div8, 01 div4, 10 div2, 11 external.
// - pin bits route data pins; clock pin driven out if either set and the clock is internal.
// - LSB first: send from bit 0, receive into bit 7.
// - load puts accumulator in low nibble, second register high.
`timescale 1ns/1ps
module csp_top
    import csp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        irq_ack,
    output logic             xfer_irq_q,
    input  wire logic        sck_in,
    output logic             sck_out_q,
    output logic             sck_oe_q,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             serial_out_oe_q,
    output logic             rx_ready_line,
    output logic             rx_ready_oe_q
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0] serial_ctrl_reg;
    logic       irq_ctrl_reg2;
    logic [7:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic       busy_q;
    logic       xfer_done_flag;
    logic       skip_taken_q;
    logic [1:0] ready_port_bit;
    logic [2:0] pre_q;
    logic       sck_prev_q;
    logic       ready_q;
    logic [31:0] rdata_q;
    logic       err_q;

    csp_clk_sel_t sel;
    logic ext_mode, instr_clock, half_tick, mapped;
    logic acc, wr, wr_ctrl, wr_shift, wr_cmd, start_ev, skip_ev;
    logic fall_ev, rise_ev, done_ev, rx_bit;
    logic [2:0] half_cnt;

    assign sel      = csp_clk_sel_t'(serial_ctrl_reg[CSP_CLK_SEL_LO +: 2]);
    assign ext_mode = (sel == CSP_SEL_EXT);
    assign mapped   = (paddr == CSP_OFS_CTRL) || (paddr == CSP_OFS_IRQC)
                   || (paddr == CSP_OFS_SHIFT) || (paddr == CSP_OFS_CMD)
                   || (paddr == CSP_OFS_RDY);
    assign acc      = psel && penable && ready_q;
    assign wr       = acc && pwrite && mapped;
    assign wr_ctrl  = wr && (paddr == CSP_OFS_CTRL);
    assign wr_shift = wr && (paddr == CSP_OFS_SHIFT);
    assign wr_cmd   = wr && (paddr == CSP_OFS_CMD);
    assign start_ev = wr_cmd && pwdata[CSP_CMD_START];
    assign skip_ev  = wr_cmd && pwdata[CSP_CMD_SKIP];
    assign prdata   = rdata_q;
    assign pready   = ready_q;
    assign pslverr  = err_q;

    // ------------------------------------------------------------
    // apb slave: setup cycle prepares answer, one access cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else if (psel && !penable) begin
            ready_q <= 1'b1;
            err_q   <= !mapped;
            rdata_q <= 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    CSP_OFS_CTRL:  rdata_q[3:0] <= serial_ctrl_reg;
                    CSP_OFS_IRQC:  rdata_q[0]   <= irq_ctrl_reg2;
                    CSP_OFS_SHIFT: rdata_q[7:0] <= shift_q;
                    CSP_OFS_CMD:   rdata_q[2:0] <= {skip_taken_q, busy_q, xfer_done_flag};
                    CSP_OFS_RDY:   rdata_q[1:0] <= ready_port_bit;
                    default:       rdata_q      <= 32'h0000_0000;
                endcase
            end
        end else begin
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_ctrl_reg <= CSP_CTRL_RST;
            irq_ctrl_reg2   <= 1'b0;
            ready_port_bit  <= CSP_RDY_RST;
        end else begin
            if (wr_ctrl) serial_ctrl_reg <= pwdata[3:0];
            if (wr && paddr == CSP_OFS_IRQC) irq_ctrl_reg2 <= pwdata[0];
            // software owns the ready handshake line
            if (wr && paddr == CSP_OFS_RDY) ready_port_bit <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // clock generation: instruction clock, then selected division
    // ------------------------------------------------------------
    csp_tick_div #(.DIV(CSP_INSTR_DIV)) u_instr (
        .pclk    (pclk),
        .presetn (presetn),
        .en      (1'b1),
        .tick_q  (instr_clock)
    );

    always_comb begin
        unique case (sel)
            CSP_SEL_DIV8: half_cnt = CSP_HALF_DIV8;
            CSP_SEL_DIV4: half_cnt = CSP_HALF_DIV4;
            CSP_SEL_DIV2: half_cnt = CSP_HALF_DIV2;
            CSP_SEL_EXT:  half_cnt = CSP_HALF_DIV2;
        endcase
    end

    assign half_tick = instr_clock && busy_q && !ext_mode && (pre_q == half_cnt - 3'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 3'h0;
        end else if (start_ev || half_tick || !busy_q) begin
            pre_q <= 3'h0;
        end else if (instr_clock) begin
            pre_q <= pre_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // shift clock edges; internal clock idles high between frames
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_in;
        end
    end

    // external clock shifts on every rising edge, even after completion
    assign fall_ev = ext_mode ? (sck_prev_q && !sck_in) : (half_tick && sck_out_q);
    assign rise_ev = ext_mode ? (!sck_prev_q && sck_in) : (half_tick && !sck_out_q);
    assign done_ev = rise_ev && busy_q && (bit_cnt_q == 3'(CSP_BITS - 1));
    // unrouted input reads as idle-high line
    assign rx_bit  = serial_ctrl_reg[CSP_PIN_SEL_IN] ? serial_in_pin : 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_out_q <= 1'b1;
        end else if (!ext_mode && half_tick) begin
            sck_out_q <= !sck_out_q;
        end else if (ext_mode || !busy_q) begin
            sck_out_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // shift register and bit counter
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= 8'h00;
        end else if (wr_shift) begin
            shift_q <= {pwdata[7:4], pwdata[3:0]};
        end else if (rise_ev) begin
            shift_q <= {rx_bit, shift_q[7:1]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin <= 1'b1;
        end else if (fall_ev) begin
            serial_out_pin <= shift_q[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q <= 3'h0;
            busy_q    <= 1'b0;
        end else if (start_ev) begin
            bit_cnt_q <= 3'h0;
            busy_q    <= 1'b1;
        end else if (done_ev) begin
            bit_cnt_q <= 3'h0;
            busy_q    <= 1'b0;
        end else if (rise_ev && busy_q) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // completion flag: set beats every clear in the same cycle
    // ------------------------------------------------------------
    logic skip_hit, irq_off;
    assign skip_hit = skip_ev && !irq_ctrl_reg2 && xfer_done_flag;
    assign irq_off  = wr && (paddr == CSP_OFS_IRQC) && !pwdata[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_done_flag <= 1'b0;
        end else if (done_ev) begin
            xfer_done_flag <= 1'b1;
        end else if (start_ev || skip_hit || (irq_ack && irq_ctrl_reg2)) begin
            xfer_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_taken_q <= 1'b0;
        end else if (skip_ev) begin
            skip_taken_q <= skip_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_irq_q <= 1'b0;
        end else begin
            xfer_irq_q <= irq_ctrl_reg2 && !irq_off && (done_ev || (xfer_done_flag
                          && !irq_ack && !start_ev && !skip_hit));
        end
    end

    // ------------------------------------------------------------
    // pin routing
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_oe_q        <= 1'b0;
            serial_out_oe_q <= 1'b0;
            rx_ready_line   <= 1'b1;
            rx_ready_oe_q   <= 1'b0;
        end else begin
            sck_oe_q <= (|serial_ctrl_reg[1:0]) && !ext_mode;
            serial_out_oe_q <= serial_ctrl_reg[CSP_PIN_SEL_OUT];
            rx_ready_line   <= ready_port_bit[CSP_RDY_LEVEL];
            rx_ready_oe_q   <= ready_port_bit[CSP_RDY_OE];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_done_set;
        @(posedge pclk) disable iff (!presetn) done_ev |=> xfer_done_flag;
    endproperty
    a_done_set: assert property (p_done_set) else $error("flag not set");

    property p_skip_clr;
        @(posedge pclk) disable iff (!presetn)
            skip_hit && !done_ev |=> !xfer_done_flag && skip_taken_q;
    endproperty
    a_skip_clr: assert property (p_skip_clr) else $error("skip did not clear");

    property p_irq_mode;
        @(posedge pclk) disable iff (!presetn) xfer_irq_q |-> xfer_done_flag && irq_ctrl_reg2;
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq without flag");

    property p_start;
        @(posedge pclk) disable iff (!presetn)
            start_ev && !done_ev |=> !xfer_done_flag && busy_q && bit_cnt_q == 3'h0;
    endproperty
    a_start: assert property (p_start) else $error("start failed");

    property p_int_stop;
        @(posedge pclk) disable iff (!presetn)
            !ext_mode && $fell(busy_q) |-> sck_out_q [*3];
    endproperty
    a_int_stop: assert property (p_int_stop) else $error("clock ran on");

    property p_ext_count;
        @(posedge pclk) disable iff (!presetn)
            $rose(xfer_done_flag) |-> $past(bit_cnt_q) == 3'h7 && $past(rise_ev);
    endproperty
    a_ext_count: assert property (p_ext_count) else $error("early flag");

    property p_lsb_out;
        @(posedge pclk) disable iff (!presetn)
            fall_ev && !wr_shift |=> serial_out_pin == $past(shift_q[0]);
    endproperty
    a_lsb_out: assert property (p_lsb_out) else $error("wrong out bit");

    property p_load;
        @(posedge pclk) disable iff (!presetn)
            wr_shift |=> shift_q[3:0] == $past(pwdata[3:0]) && shift_q[7:4] == $past(pwdata[7:4]);
    endproperty
    a_load: assert property (p_load) else $error("load mismatch");

    property p_pins;
        @(posedge pclk) disable iff (!presetn)
            sck_oe_q |-> $past(|serial_ctrl_reg[1:0]);
    endproperty
    a_pins: assert property (p_pins) else $error("clock pin unrouted");

    c_int_done: cover property (@(posedge pclk) disable iff (!presetn)
        !ext_mode && done_ev);
    c_ext_done: cover property (@(posedge pclk) disable iff (!presetn)
        ext_mode && done_ev);
    c_skip: cover property (@(posedge pclk) disable iff (!presetn) skip_hit);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) xfer_irq_q && irq_ack);
endmodule

// ===== core/csp_pkg.sv
// Purpose: shared constants of the clocked serial shift port
// Assumes: 32-bit APB, pclk at 10 MHz
// Notes:   register offsets are byte addresses
package csp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CSP_OFS_CTRL  = 8'h00;
    localparam logic [7:0] CSP_OFS_IRQC  = 8'h04;
    localparam logic [7:0] CSP_OFS_SHIFT = 8'h08;
    localparam logic [7:0] CSP_OFS_CMD   = 8'h0C;
    localparam logic [7:0] CSP_OFS_RDY   = 8'h10;
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int CSP_CLK_SEL_LO  = 2;
    localparam int CSP_PIN_SEL_IN  = 1;
    localparam int CSP_PIN_SEL_OUT = 0;
    localparam int CSP_CMD_START   = 0;
    localparam int CSP_CMD_SKIP    = 1;
    localparam int CSP_RDY_LEVEL   = 0;
    localparam int CSP_RDY_OE      = 1;
    localparam int CSP_BITS        = 8;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] CSP_CTRL_RST = 4'h0;
    localparam logic [1:0] CSP_RDY_RST  = 2'h1;
    // ------------------------------------------------------------
    // timing: instruction clock and clock-select encodings
    // ------------------------------------------------------------
    localparam int CSP_PCLK_HZ  = 10000000;
    localparam int CSP_INSTR_HZ = 1000000;
    localparam int CSP_INSTR_DIV = CSP_PCLK_HZ / CSP_INSTR_HZ;
    typedef enum logic [1:0] {
        CSP_SEL_DIV8 = 2'b00,
        CSP_SEL_DIV4 = 2'b01,
        CSP_SEL_DIV2 = 2'b10,
        CSP_SEL_EXT  = 2'b11
    } csp_clk_sel_t;
    // half periods of the shift clock, in instruction clocks
    localparam logic [2:0] CSP_HALF_DIV8 = 3'h4;
    localparam logic [2:0] CSP_HALF_DIV4 = 3'h2;
    localparam logic [2:0] CSP_HALF_DIV2 = 3'h1;
endpackage

// ===== core/csp_tick_div.sv
// Purpose: one-cycle enable pulse every DIV clocks
// Assumes: DIV of at least 1
// Notes:   dropping en forces the count back to zero
`timescale 1ns/1ps
module csp_tick_div #(
    parameter int DIV = 2
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic en,
    output logic      tick_q
);
    logic [15:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else if (!en) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else if (cnt_q == 16'(DIV - 1)) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end
endmodule

// ===== test/csp_far_end.sv
// Purpose: far-end serial device facing the shift port
// Assumes: pulled-up lines; shift clock idles high
// Notes:   reacts to the port's clock, or makes its own on request
`timescale 1ns/1ps
module csp_far_end (
    input  wire logic pclk,
    input  wire logic sck,
    input  wire logic sck_oe_q,
    input  wire logic serial_out_pin,
    input  wire logic serial_out_oe_q,
    output logic      sck_drv,
    output logic      serial_in_pin
);
    logic [7:0] tx_b;
    logic [7:0] rx_b;
    logic [3:0] idx;
    logic       sck_p;
    logic       dout;
    int         t;
    int         half;
    // a released data line is pulled high
    assign dout = serial_out_oe_q ? serial_out_pin : 1'b1;
    initial begin
        sck_drv = 1'b1;
        serial_in_pin = 1'b1;
        sck_p = 1'b1;
        tx_b = 8'hFF;
        rx_b = 8'h00;
        idx = 4'h0;
        t = 0;
        half = 0;
    end
    // slave side: data out after falling edge, sample on rising edge
    always @(posedge pclk) begin
        sck_p <= sck;
        t <= t + 1;
        if (sck_oe_q && sck_p && !sck) begin
            serial_in_pin <= tx_b[idx[2:0]];
            t <= 1;
        end
        if (sck_oe_q && !sck_p && sck) begin
            rx_b <= {dout, rx_b[7:1]};
            half <= t;
            idx <= idx + 4'h1;
        end
    end
    task automatic load(input logic [7:0] b);
        tx_b = b;
        idx = 4'h0;
    endtask
    // master side: n clock pulses of hp pclk per half, then stop high
    task automatic ext_pulses(input int n, input int hp);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            sck_drv <= 1'b0;
            serial_in_pin <= tx_b[idx[2:0]];
            repeat (hp) @(posedge pclk);
            rx_b <= {dout, rx_b[7:1]};
            sck_drv <= 1'b1;
            idx <= idx + 4'h1;
            repeat (hp) @(posedge pclk);
        end
        serial_in_pin <= 1'b1;
    endtask
endmodule

// ===== test/clocked_serial_shift_port_test.sv
// Purpose: register-level test of the serial shift port
// Assumes: APB answers in one access cycle; far end is csp_far_end
// Notes:   every wait is bounded; bench drives at rising edges
`timescale 1ns/1ps
module clocked_serial_shift_port_test import csp_pkg::*;;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_ack;
    logic        xfer_irq_q;
    logic        sck_wire;
    logic        far_sck;
    logic        sck_out_q;
    logic        sck_oe_q;
    logic        serial_in_pin;
    logic        serial_out_pin;
    logic        serial_out_oe_q;
    logic        rx_ready_line;
    logic        rx_ready_oe_q;
    logic [31:0] rd;
    logic        slv;
    logic [6:0]  pins;
    int          errors;
    int          compares;
    // shared clock pin: whoever enables drives it
    assign sck_wire = sck_oe_q ? sck_out_q : far_sck;
    assign pins = {sck_out_q, sck_oe_q, serial_out_pin, serial_out_oe_q,
                   rx_ready_line, rx_ready_oe_q, xfer_irq_q};
    csp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq_ack, .xfer_irq_q, .sck_in(sck_wire),
        .sck_out_q, .sck_oe_q, .serial_in_pin, .serial_out_pin,
        .serial_out_oe_q, .rx_ready_line, .rx_ready_oe_q);
    csp_far_end far (.pclk, .sck(sck_wire), .sck_oe_q, .serial_out_pin,
        .serial_out_oe_q, .sck_drv(far_sck), .serial_in_pin);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            errors++;
            end_of_test();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, CSP_OFS_CMD, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 400);
        if (rd[0] !== 1'b1) begin
            errors++;
            end_of_test();
        end
    endtask
    // internal-clock transfer; half period in pclk = (4 >> sel) * 10
    task automatic xfer(input logic [3:0] c, input logic [7:0] b);
        apb(1'b1, CSP_OFS_CTRL, {28'h0, c});
        // pin enables are registered behind the control register
        repeat (2) @(posedge pclk);
        check(32'({sck_oe_q, serial_out_oe_q}), 32'({c[0] | c[1], c[0]}));
        apb(1'b1, CSP_OFS_SHIFT, {24'h0, b});
        apb(1'b0, CSP_OFS_SHIFT, 32'h0);
        check(rd, {24'h0, b});
        far.load(~b);
        apb(1'b1, CSP_OFS_CMD, 32'h1);
        apb(1'b0, CSP_OFS_CMD, 32'h0);
        check({30'h0, rd[1:0]}, 32'h2);
        wait_done();
        check(32'(far.rx_b), {24'h0, c[0] ? b : 8'hFF});
        check(32'(far.half), 32'((4 >> c[3:2]) * CSP_INSTR_DIV));
        apb(1'b0, CSP_OFS_SHIFT, 32'h0);
        check(rd, {24'h0, c[1] ? ~b : 8'hFF});
        check(32'(sck_out_q), 32'h1);
    endtask
    initial begin
        repeat (100000) @(posedge pclk);
        errors++;
        end_of_test();
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        logic [3:0] cs [4];
        logic [7:0] bs [4];
        cs = '{4'h3, 4'h5, 4'hA, 4'h1};
        bs = '{8'h5A, 8'hC3, 8'h81, 8'h96};
        presetn = 1'b0;
        {psel, penable, pwrite, irq_ack} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        compares = 0;
        repeat (8) @(posedge pclk);
        check(32'(pins), 32'h54);
        presetn <= 1'b1;
        apb(1'b0, CSP_OFS_CTRL, 32'h0);
        check(rd, 32'(CSP_CTRL_RST));
        apb(1'b0, CSP_OFS_RDY, 32'h0);
        check(rd, 32'(CSP_RDY_RST));
        apb(1'b0, 8'h14, 32'h0);
        check({rd[30:0], slv}, 32'h1);
        apb(1'b1, CSP_OFS_CTRL, 32'hFFFF_FFFF);
        apb(1'b0, CSP_OFS_CTRL, 32'h0);
        check(rd, 32'hF);
        $display("test reset done");
        for (int i = 0; i < 4; i++) xfer(cs[i], bs[i]);
        $display("test internal clock done");
        apb(1'b1, CSP_OFS_CMD, 32'h2);
        apb(1'b0, CSP_OFS_CMD, 32'h0);
        check({29'h0, rd[2:0]}, 32'h4);
        apb(1'b1, CSP_OFS_IRQC, 32'h1);
        xfer(4'hB, 8'h3C);
        check(32'(xfer_irq_q), 32'h1);
        apb(1'b1, CSP_OFS_CMD, 32'h2);
        apb(1'b0, CSP_OFS_CMD, 32'h0);
        check({31'h0, rd[0]}, 32'h1);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge pclk);
        check(32'(xfer_irq_q), 32'h0);
        apb(1'b0, CSP_OFS_CMD, 32'h0);
        check({31'h0, rd[0]}, 32'h0);
        $display("test skip and interrupt done");
        apb(1'b1, CSP_OFS_IRQC, 32'h0);
        apb(1'b1, CSP_OFS_CTRL, {28'h0, CSP_SEL_EXT, 2'b11});
        apb(1'b1, CSP_OFS_SHIFT, 32'hA5);
        far.load(8'h5A);
        apb(1'b1, CSP_OFS_CMD, 32'h1);
        far.ext_pulses(7, 5);
        apb(1'b0, CSP_OFS_CMD, 32'h0);
        check({31'h0, rd[0]}, 32'h0);
        far.ext_pulses(1, 5);
        apb(1'b0, CSP_OFS_CMD, 32'h0);
        check({31'h0, rd[0]}, 32'h1);
        check(32'(far.rx_b), 32'hA5);
        far.load(8'hC6);
        far.ext_pulses(8, 5);
        apb(1'b0, CSP_OFS_SHIFT, 32'h0);
        check(rd, 32'hC6);
        check(32'(far.rx_b), 32'h5A);
        $display("test external clock done");
        apb(1'b1, CSP_OFS_RDY, 32'h3);
        repeat (2) @(posedge pclk);
        check(32'({rx_ready_oe_q, rx_ready_line}), 32'h3);
        apb(1'b1, CSP_OFS_SHIFT, 32'h3C);
        apb(1'b1, CSP_OFS_CMD, 32'h1);
        apb(1'b1, CSP_OFS_RDY, 32'h2);
        repeat (2) @(posedge pclk);
        check(32'({rx_ready_oe_q, rx_ready_line}), 32'h2);
        far.load(8'h99);
        // master reads the ready line as an input and clocks only on low
        if (rx_ready_line === 1'b0) far.ext_pulses(8, 5);
        wait_done();
        apb(1'b1, CSP_OFS_RDY, 32'h3);
        repeat (2) @(posedge pclk);
        check(32'({rx_ready_oe_q, rx_ready_line}), 32'h3);
        apb(1'b0, CSP_OFS_SHIFT, 32'h0);
        check(rd, 32'h99);
        check(32'(far.rx_b), 32'h3C);
        // gap a master leaves before the next byte
        repeat (20) @(posedge pclk);
        apb(1'b0, CSP_OFS_RDY, 32'h0);
        check(rd, 32'h3);
        $display("test ready line done");
        end_of_test();
    end
endmodule
